// ---- src/iox_cfg.svh ----
// Constants of the I/O expander: command codes, reset values, timing counts.
// Assumes a 20 MHz core clock; included by bare name.
`ifndef IOX_CFG_SVH
`define IOX_CFG_SVH

// -----------------------------------------------------------------------------
// Command byte register selections
// -----------------------------------------------------------------------------
`define IOX_CMD_LVL_A   3'h0
`define IOX_CMD_LVL_B   3'h1
`define IOX_CMD_OUT_A   3'h2
`define IOX_CMD_OUT_B   3'h3
`define IOX_CMD_DIR_A   3'h4
`define IOX_CMD_DIR_B   3'h5
`define IOX_CMD_MSK_A   3'h6
`define IOX_CMD_MSK_B   3'h7

// -----------------------------------------------------------------------------
// Reset values and target address
// -----------------------------------------------------------------------------
`define IOX_DIR_RESET   8'h00
`define IOX_MSK_RESET   8'h00
`define IOX_ADDR_UPPER  5'h16
`define IOX_ADDR_LO_POS 0
`define IOX_ADDR_HI_POS 1

// -----------------------------------------------------------------------------
// Timing: figures as printed, cycle counts derived from the clock period
// -----------------------------------------------------------------------------
`define IOX_CLK_PERIOD_NS 50
`define IOX_SPIKE_NS      50
`define IOX_TPV_NS        4000
`define IOX_TIV_NS        4000
`define IOX_TIR_NS        4000
`define IOX_SPIKE_CYC ((`IOX_SPIKE_NS + `IOX_CLK_PERIOD_NS - 1) / `IOX_CLK_PERIOD_NS)
`define IOX_TPV_CYC   (`IOX_TPV_NS / `IOX_CLK_PERIOD_NS)
`define IOX_TIV_CYC   (`IOX_TIV_NS / `IOX_CLK_PERIOD_NS)
`define IOX_TIR_CYC   (`IOX_TIR_NS / `IOX_CLK_PERIOD_NS)

`endif

// ---- src/iox_pkg.sv ----
// Types shared by the I/O expander modules.
// Assumes nothing beyond a SystemVerilog compiler.
package iox_pkg;

  // Serial target sequencer states
  typedef enum logic [3:0] {
    IOX_IDLE, IOX_ADDR, IOX_ADDR_ACK, IOX_CMD, IOX_CMD_ACK,
    IOX_WDATA, IOX_WDATA_ACK, IOX_RDATA, IOX_RACK
  } iox_i2c_state_type;

  // Software-visible writable registers
  typedef struct packed {
    logic [7:0] outA;
    logic [7:0] outB;
    logic [7:0] dirA;
    logic [7:0] dirB;
    logic [7:0] mskA;
    logic [7:0] mskB;
  } iox_regs_type;

endpackage : iox_pkg

// ---- src/iox_line_if.sv ----
// Carrier for one filtered serial line between the core and its filter.
// Assumes the raw level is already synchronous to the core clock.
`timescale 1ns/100ps
`default_nettype none
interface iox_line_if;
  logic raw;
  logic clean;
  modport filt (input raw, output clean);
  modport user (output raw, input clean);
endinterface : iox_line_if
`default_nettype wire

// ---- src/iox_glitch_filter.sv ----
// Spike filter for one serial line: a change passes only once it is held.
// Assumes raw is synchronous to core_clk; idles high after reset.
`timescale 1ns/100ps
`default_nettype none
`include "iox_cfg.svh"
module iox_glitch_filter #(
  parameter int unsigned HOLD_CYC = `IOX_SPIKE_CYC
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // Filtered line
  iox_line_if.filt  line
);

  typedef struct packed {
    logic [3:0] cnt;
    logic       clean;
  } iox_filt_state_type;

  iox_filt_state_type stQ;
  iox_filt_state_type stD;

  // Accept a new level only after it has stood for HOLD_CYC extra samples
  always_comb begin
    stD = stQ;
    if (line.raw == stQ.clean) begin
      stD.cnt = 4'h0;
    end else if (stQ.cnt == 4'(HOLD_CYC)) begin
      stD.clean = line.raw;
      stD.cnt   = 4'h0;
    end else begin
      stD.cnt = stQ.cnt + 4'h1;
    end
    if (!rst_n) begin
      stD.cnt   = 4'h0;
      stD.clean = 1'b1; // Bus idles high
    end
  end

  always_ff @(posedge core_clk) begin
    stQ <= stD;
  end

  assign line.clean = stQ.clean;

  // A one-sample spike never reaches the clean output
  property p_spike;
    @(posedge core_clk) disable iff (!rst_n)
      $changed(stQ.clean) |-> ($past(line.raw) == stQ.clean) && ($past(line.raw, 2) == stQ.clean);
  endproperty
  a_spike: assert property (p_spike) else $error("filter passed a short spike");

endmodule : iox_glitch_filter
`default_nettype wire

// ---- src/iox_expander.sv ----
// Sixteen-line I/O expander core behind a two-wire serial target.
// Assumes all pins are synchronous to core_clk; pads resolve out/oe pairs.
//
// Overview of operation
// - Command byte selects one of eight registers
// - Level registers read-only, others read/write
// - Direction and mask registers reset to zero
// - Output defaults from address pins, nibble-wise
// - Low strap gives 0, high strap gives 1
// - Written output value reaches pins within 4us
// - Input change raises alert within 4us
// - Alert drops within 4us of read ack
// - Spikes under 50ns on serial lines ignored
// - Direction bit 1 input, 0 output
// - Mask bit 1 disables change detection
// - Only reading changed bank's level clears alert
// - Bus clear idles interface, alert untouched
`timescale 1ns/100ps
`default_nettype none
`include "iox_cfg.svh"
module iox_expander (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // Serial interface
  input  wire logic       busClearN,
  input  wire logic       sclIn,
  input  wire logic       sdaIn,
  output var  logic       sdaOut,
  output var  logic       sdaOe,
  // Address straps
  input  wire logic       addrSelectLo,
  input  wire logic       addrSelectHi,
  // Bank A, open-drain lines
  input  wire logic [7:0] opendrainIn,
  output var  logic [7:0] opendrainOut,
  output var  logic [7:0] opendrainOe,
  // Bank B, push-pull lines
  input  wire logic [7:0] pushpullIn,
  output var  logic [7:0] pushpullOut,
  output var  logic [7:0] pushpullOe,
  // Change alert, open-drain, active low
  output var  logic       changeAlertNOut,
  output var  logic       changeAlertNOe
);

  localparam int TpvCyc = `IOX_TPV_CYC;
  localparam int TivCyc = `IOX_TIV_CYC;
  localparam int TirCyc = `IOX_TIR_CYC;

  typedef struct packed {
    iox_pkg::iox_i2c_state_type st;
    logic [3:0]                 bitCnt;
    logic [7:0]                 shift;
    logic [2:0]                 cmd;
    logic                       mAck;
    logic                       prevScl;
    logic                       prevSda;
    iox_pkg::iox_regs_type      regs;
    logic [7:0]                 lvlA;
    logic [7:0]                 lvlB;
    logic [1:0]                 pend;
    logic                       sdaOe;
    logic [7:0]                 odOe;
    logic [7:0]                 ppOut;
    logic [7:0]                 ppOe;
    logic                       alertOe;
  } iox_core_state_type;

  iox_core_state_type stQ;
  iox_core_state_type stD;
  logic               wrStb;
  logic [2:0]         wrCmd;
  logic [7:0]         wrData;
  logic               clrA;
  logic               clrB;
  logic [1:0]         chgVec;
  logic               scl;
  logic               sda;
  logic               sclRise;
  logic               sclFall;
  logic               startC;
  logic               stopC;
  logic [6:0]         ownAddr;

  // ---------------------------------------------------------------------------
  // Serial line filters
  // ---------------------------------------------------------------------------
  iox_line_if sclLine ();
  iox_line_if sdaLine ();
  assign sclLine.raw = sclIn;
  assign sdaLine.raw = sdaIn;

  iox_glitch_filter #(.HOLD_CYC(`IOX_SPIKE_CYC)) u_sclFilt (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .line     (sclLine.filt)
  );
  iox_glitch_filter #(.HOLD_CYC(`IOX_SPIKE_CYC)) u_sdaFilt (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .line     (sdaLine.filt)
  );

  // Line events; START and STOP only while the clock stands high
  assign scl     = sclLine.clean;
  assign sda     = sdaLine.clean;
  assign sclRise = scl & ~stQ.prevScl;
  assign sclFall = ~scl & stQ.prevScl;
  assign startC  = scl & stQ.prevScl & stQ.prevSda & ~sda;
  assign stopC   = scl & stQ.prevScl & ~stQ.prevSda & sda;
  assign ownAddr = {`IOX_ADDR_UPPER, addrSelectHi, addrSelectLo};

  // Read multiplexer over the command selection
  function automatic logic [7:0] rdByte(input iox_core_state_type s, input logic [2:0] c);
    case (c)
      `IOX_CMD_LVL_A: rdByte = s.lvlA;
      `IOX_CMD_LVL_B: rdByte = s.lvlB;
      `IOX_CMD_OUT_A: rdByte = s.regs.outA;
      `IOX_CMD_OUT_B: rdByte = s.regs.outB;
      `IOX_CMD_DIR_A: rdByte = s.regs.dirA;
      `IOX_CMD_DIR_B: rdByte = s.regs.dirB;
      `IOX_CMD_MSK_A: rdByte = s.regs.mskA;
      default:        rdByte = s.regs.mskB;
    endcase
  endfunction : rdByte

  // ---------------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------------
  always_comb begin
    stD         = stQ;
    wrStb       = 1'b0;
    wrCmd       = stQ.cmd;
    wrData      = stQ.shift;
    clrA        = 1'b0;
    clrB        = 1'b0;
    stD.prevScl = scl;
    stD.prevSda = sda;
    // Bus clear wins over everything on the serial side
    if (!busClearN) begin
      stD.st    = iox_pkg::IOX_IDLE;
      stD.sdaOe = 1'b0;
    end else if (startC) begin
      stD.st     = iox_pkg::IOX_ADDR;
      stD.bitCnt = 4'h0;
      stD.sdaOe  = 1'b0;
    end else if (stopC) begin
      stD.st    = iox_pkg::IOX_IDLE;
      stD.sdaOe = 1'b0;
    end else begin
      case (stQ.st)
        iox_pkg::IOX_ADDR, iox_pkg::IOX_CMD, iox_pkg::IOX_WDATA: begin
          if (sclRise) begin
            stD.shift  = {stQ.shift[6:0], sda};
            stD.bitCnt = stQ.bitCnt + 4'h1;
          end else if (sclFall && stQ.bitCnt == 4'h8) begin
            stD.bitCnt = 4'h0;
            stD.sdaOe  = 1'b1;
            if (stQ.st == iox_pkg::IOX_ADDR) begin
              // Foreign address: stay off the bus until the next START
              if (stQ.shift[7:1] == ownAddr) begin
                stD.st = iox_pkg::IOX_ADDR_ACK;
              end else begin
                stD.st    = iox_pkg::IOX_IDLE;
                stD.sdaOe = 1'b0;
              end
              stD.mAck = stQ.shift[0]; // Holds R/W until the ack ends
            end else if (stQ.st == iox_pkg::IOX_CMD) begin
              stD.cmd = stQ.shift[2:0];
              stD.st  = iox_pkg::IOX_CMD_ACK;
            end else begin
              wrStb  = 1'b1;
              stD.st = iox_pkg::IOX_WDATA_ACK;
            end
          end
        end
        iox_pkg::IOX_ADDR_ACK, iox_pkg::IOX_CMD_ACK, iox_pkg::IOX_WDATA_ACK: begin
          if (sclFall) begin
            stD.sdaOe = 1'b0;
            if (stQ.st == iox_pkg::IOX_ADDR_ACK && stQ.mAck) begin
              stD.shift = rdByte(stQ, stQ.cmd);
              stD.sdaOe = ~stD.shift[7];
              stD.st    = iox_pkg::IOX_RDATA;
            end else if (stQ.st == iox_pkg::IOX_ADDR_ACK) begin
              stD.st = iox_pkg::IOX_CMD;
            end else begin
              // Further data bytes rewrite the same register
              stD.st = iox_pkg::IOX_WDATA;
            end
          end
        end
        iox_pkg::IOX_RDATA: begin
          if (sclFall) begin
            if (stQ.bitCnt == 4'h7) begin
              stD.sdaOe  = 1'b0;
              stD.bitCnt = 4'h0;
              stD.st     = iox_pkg::IOX_RACK;
            end else begin
              stD.shift  = {stQ.shift[6:0], 1'b0};
              stD.sdaOe  = ~stQ.shift[6];
              stD.bitCnt = stQ.bitCnt + 4'h1;
            end
          end
        end
        iox_pkg::IOX_RACK: begin
          if (sclRise) begin
            stD.mAck = ~sda;
            clrA     = (stQ.cmd == `IOX_CMD_LVL_A);
            clrB     = (stQ.cmd == `IOX_CMD_LVL_B);
          end else if (sclFall) begin
            if (stQ.mAck) begin
              stD.shift = rdByte(stQ, stQ.cmd);
              stD.sdaOe = ~stD.shift[7];
              stD.st    = iox_pkg::IOX_RDATA;
            end else begin
              stD.st = iox_pkg::IOX_IDLE;
            end
          end
        end
        default: stD.st = iox_pkg::IOX_IDLE;
      endcase
    end

    // Register writes; the level registers ignore writes
    if (wrStb) begin
      case (wrCmd)
        `IOX_CMD_OUT_A: stD.regs.outA = wrData;
        `IOX_CMD_OUT_B: stD.regs.outB = wrData;
        `IOX_CMD_DIR_A: stD.regs.dirA = wrData;
        `IOX_CMD_DIR_B: stD.regs.dirB = wrData;
        `IOX_CMD_MSK_A: stD.regs.mskA = wrData;
        `IOX_CMD_MSK_B: stD.regs.mskB = wrData;
        default:        stD.regs = stQ.regs;
      endcase
    end

    // Change detection on unmasked input lines; a set beats a same-cycle clear
    chgVec[0] = |((opendrainIn ^ stQ.lvlA) & stQ.regs.dirA & ~stQ.regs.mskA);
    chgVec[1] = |((pushpullIn ^ stQ.lvlB) & stQ.regs.dirB & ~stQ.regs.mskB);
    stD.pend  = (stQ.pend & ~{clrB, clrA}) | chgVec;
    stD.lvlA  = opendrainIn;
    stD.lvlB  = pushpullIn;

    // Power-up defaults; straps are sampled while reset is held
    if (!rst_n) begin
      stD.st          = iox_pkg::IOX_IDLE;
      stD.bitCnt      = 4'h0;
      stD.shift       = 8'h00;
      stD.cmd         = 3'h0;
      stD.mAck        = 1'b0;
      stD.sdaOe       = 1'b0;
      stD.pend        = 2'h0;
      stD.regs.outA   = {{4{addrSelectHi}}, {4{addrSelectLo}}};
      stD.regs.outB   = {{4{addrSelectHi}}, {4{addrSelectLo}}};
      stD.regs.dirA   = `IOX_DIR_RESET;
      stD.regs.dirB   = `IOX_DIR_RESET;
      stD.regs.mskA   = `IOX_MSK_RESET;
      stD.regs.mskB   = `IOX_MSK_RESET;
    end

    // Pin drive from the new register values, one cycle after a write
    stD.odOe    = ~stD.regs.dirA & ~stD.regs.outA;
    stD.ppOut   = stD.regs.outB;
    stD.ppOe    = ~stD.regs.dirB;
    stD.alertOe = |stD.pend;
  end

  always_ff @(posedge core_clk) begin
    stQ <= stD;
  end

  // Open-drain outputs only ever pull low
  assign sdaOut          = 1'b0;
  assign sdaOe           = stQ.sdaOe;
  assign opendrainOut    = 8'h00;
  assign opendrainOe     = stQ.odOe;
  assign pushpullOut     = stQ.ppOut;
  assign pushpullOe      = stQ.ppOe;
  assign changeAlertNOut = 1'b0;
  assign changeAlertNOe  = stQ.alertOe;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  property p_cfgReset;
    $rose(rst_n) |-> (stQ.regs.dirA == 8'h00) && (stQ.regs.dirB == 8'h00)
                     && (stQ.regs.mskA == 8'h00) && (stQ.regs.mskB == 8'h00);
  endproperty
  a_cfgReset: assert property (p_cfgReset) else $error("config not cleared");

  property p_strap;
    $rose(rst_n) |-> stQ.regs.outB == {{4{$past(addrSelectHi)}}, {4{$past(addrSelectLo)}}};
  endproperty
  a_strap: assert property (p_strap) else $error("output default wrong");

  property p_outVal;
    (wrStb && wrCmd == `IOX_CMD_OUT_B) |-> ##[1:TpvCyc] (pushpullOut == $past(wrData, 1));
  endproperty
  a_outVal: assert property (p_outVal) else $error("output value late");

  property p_dirB;
    (wrStb && wrCmd == `IOX_CMD_DIR_B) |=> pushpullOe == ~$past(wrData);
  endproperty
  a_dirB: assert property (p_dirB) else $error("direction not honoured");

  property p_alertSet;
    chgVec[0] |-> ##[1:TivCyc] changeAlertNOe;
  endproperty
  a_alertSet: assert property (p_alertSet) else $error("alert missing");

  property p_mask;
    (!stQ.pend[1] && (stQ.regs.mskB | ~stQ.regs.dirB) == 8'hff) |=> !stQ.pend[1];
  endproperty
  a_mask: assert property (p_mask) else $error("spurious pending");

  property p_alertClr;
    (clrA && stQ.pend == 2'h1 && chgVec == 2'h0) ##1 (chgVec == 2'h0)
      |-> ##[1:TirCyc] !changeAlertNOe;
  endproperty
  a_alertClr: assert property (p_alertClr) else $error("alert not released");

  property p_bankSep;
    (clrB && stQ.pend[0]) |=> stQ.pend[0];
  endproperty
  a_bankSep: assert property (p_bankSep) else $error("wrong bank cleared");

  property p_busClear;
    (!busClearN && !stopC) |=> (stQ.st == iox_pkg::IOX_IDLE) && !sdaOe
                                && (stQ.pend == ($past(stQ.pend) | $past(chgVec)));
  endproperty
  a_busClear: assert property (p_busClear) else $error("bus clear failed");

  property p_roLevel;
    (wrStb && wrCmd <= `IOX_CMD_LVL_B) |=> $stable(stQ.regs);
  endproperty
  a_roLevel: assert property (p_roLevel) else $error("level register written");

  property p_addr;
    (stQ.st == iox_pkg::IOX_ADDR && sclFall && stQ.bitCnt == 4'h8 && busClearN
      && !startC && stQ.shift[7:1] != ownAddr) |=> (stQ.st == iox_pkg::IOX_IDLE) && !sdaOe;
  endproperty
  a_addr: assert property (p_addr) else $error("foreign address acked");

endmodule : iox_expander
`default_nettype wire

// ---- tb/iox_i2c_ctrl_model.sv ----
// Two-wire bus controller model that drives the expander's serial target.
// Assumes the bench resolves the data line with a pull-up and feeds it back.
`timescale 1ns/100ps
`default_nettype none
module iox_i2c_ctrl_model (
  // Clock
  input  wire logic core_clk,
  // Bus lines
  output var  logic sclOut,
  output var  logic sdaLow,
  input  wire logic sdaLine
);
  // ---------------------------------------------------------------------------
  // Pacing: half bit period in core cycles, optional clock spike
  // ---------------------------------------------------------------------------
  int halfCyc = 8;
  bit spike   = 1'b0;

  // Bus idles released
  initial begin
    sclOut = 1'b1;
    sdaLow = 1'b0;
  end

  // Every line change lands just after a rising edge
  task automatic hold(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : hold

  // Data moves mid low phase only, so it never fakes a START or STOP
  task automatic bit_io(input logic b, output logic s);
    hold(halfCyc / 2);
    sdaLow = ~b;
    if (spike) begin
      hold(1);
      sclOut = 1'b1; // One-cycle pulse, shorter than the filter hold
      hold(1);
      sclOut = 1'b0;
    end
    hold(halfCyc / 2);
    sclOut = 1'b1;
    hold(halfCyc);
    s      = sdaLine;
    sclOut = 1'b0;
  endtask : bit_io

  // Start from an idle bus
  task automatic start();
    hold(halfCyc);
    sdaLow = 1'b1;
    hold(halfCyc);
    sclOut = 1'b0;
  endtask : start

  // Repeated start from clock low
  task automatic rstart();
    hold(halfCyc / 2);
    sdaLow = 1'b0;
    hold(halfCyc / 2);
    sclOut = 1'b1;
    start();
  endtask : rstart

  // Stop from clock low
  task automatic stop();
    hold(halfCyc / 2);
    sdaLow = 1'b1;
    hold(halfCyc / 2);
    sclOut = 1'b1;
    hold(halfCyc);
    sdaLow = 1'b0;
    hold(halfCyc);
  endtask : stop

  // Byte out, MSB first, then the target's acknowledge
  task automatic byte_out(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask : byte_out

  // Address, command, one data byte
  task automatic write_reg(input logic [6:0] adr, input logic [7:0] cmd,
                           input logic [7:0] d, output logic ok);
    logic a1, a2, a3;
    start();
    byte_out({adr, 1'b0}, a1);
    byte_out(cmd, a2);
    byte_out(d, a3);
    stop();
    ok = a1 & a2 & a3;
  endtask : write_reg

  // Command, repeated start, one byte read and refused with a nack
  task automatic read_reg(input logic [6:0] adr, input logic [7:0] cmd,
                          output logic [7:0] d, output logic ok);
    logic a1, a2, a3, s;
    start();
    byte_out({adr, 1'b0}, a1);
    byte_out(cmd, a2);
    rstart();
    byte_out({adr, 1'b1}, a3);
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(1'b1, s);
    stop();
    ok = a1 & a2 & a3;
  endtask : read_reg
endmodule : iox_i2c_ctrl_model
`default_nettype wire

// ---- tb/test_i2c_sixteen_bit_io_expander.sv ----
// Self-checking bench for the I/O expander: registers, pins, alert, bus clear.
// Assumes the controller model; straps fixed from reset on, pull-ups on lines.
`timescale 1ns/100ps
`default_nettype none
`include "iox_cfg.svh"
module test_i2c_sixteen_bit_io_expander;
  // ---------------------------------------------------------------------------
  // Signals and pad resolution
  // ---------------------------------------------------------------------------
  logic        core_clk;
  logic        rst_n;
  logic        busClearN;
  logic        addrSelectLo;
  logic        addrSelectHi;
  logic        sclLine;
  logic        ctrlSdaLow;
  logic        sdaOut;
  logic        sdaOe;
  logic        changeAlertNOut;
  logic        changeAlertNOe;
  logic [7:0]  odExt;
  logic [7:0]  ppExt;
  logic [7:0]  opendrainOut;
  logic [7:0]  opendrainOe;
  logic [7:0]  pushpullOut;
  logic [7:0]  pushpullOe;
  wire         sdaLine = ~ctrlSdaLow & (sdaOe ? sdaOut : 1'b1);
  wire  [7:0]  odLine  = odExt & ((opendrainOut & opendrainOe) | ~opendrainOe);
  wire         alertPin = changeAlertNOe ? changeAlertNOut : 1'b1;
  wire  [7:0]  ppLine  = (pushpullOut & pushpullOe) | (ppExt & ~pushpullOe);
  int          n_errors;
  int          checked;
  int          cyc;
  int          rm[8];
  logic [15:0] lfsr;
  logic [7:0]  rd;
  logic        ok;
  logic [6:0]  me;

  iox_expander i_dut (
    .core_clk(core_clk), .rst_n(rst_n), .busClearN(busClearN), .sclIn(sclLine),
    .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe), .addrSelectLo(addrSelectLo),
    .addrSelectHi(addrSelectHi), .opendrainIn(odLine), .opendrainOut(opendrainOut),
    .opendrainOe(opendrainOe), .pushpullIn(ppLine), .pushpullOut(pushpullOut),
    .pushpullOe(pushpullOe), .changeAlertNOut(changeAlertNOut),
    .changeAlertNOe(changeAlertNOe));

  iox_i2c_ctrl_model i_ctrl (.core_clk(core_clk), .sclOut(sclLine), .sdaLow(ctrlSdaLow),
                             .sdaLine(sdaLine));

  // ---------------------------------------------------------------------------
  // Clock, timeout, helpers
  // ---------------------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // Ceiling well above the roughly 26k cycles the sequence needs
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 90000) begin
      n_errors++;
      wrap_up();
    end
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input int c, input logic [7:0] val);
    rm[c] = val;
    i_ctrl.write_reg(me, c[7:0], val, ok);
    check("write ack", {7'h0, ok}, 8'h01);
  endtask : wr

  task automatic rd_chk(input int c);
    i_ctrl.read_reg(me, c[7:0], rd, ok);
    check("read ack", {7'h0, ok}, 8'h01);
    check("register", rd, rm[c][7:0]);
  endtask : rd_chk

  // Pad controls follow the register model
  task automatic check_pins();
    check("pp drive", pushpullOut, rm[3][7:0]);
    check("pp enable", pushpullOe, ~rm[5][7:0]);
    check("od enable", opendrainOe, ~rm[4][7:0] & ~rm[2][7:0]);
  endtask : check_pins

  // Bounded wait for the alert to reach a level
  task automatic wait_alert(input logic lvl);
    int n;
    n = 0;
    while (changeAlertNOe !== lvl && n < `IOX_TIV_CYC) begin
      i_ctrl.hold(1);
      n++;
    end
    check("alert", {7'h0, changeAlertNOe}, {7'h0, lvl});
  endtask : wait_alert

  task automatic wrap_up();
    $display("Comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    rst_n = 1'b0; busClearN = 1'b1; addrSelectHi = 1'b1; addrSelectLo = 1'b0;
    odExt = 8'hff; ppExt = 8'h00; lfsr = 16'h0001; n_errors = 0; checked = 0; cyc = 0;
    me = {`IOX_ADDR_UPPER, 1'b1, 1'b0};
    rm = '{0, 0, 'hf0, 'hf0, 0, 0, 0, 0};
    repeat (12) @(posedge core_clk);
    #1 rst_n = 1'b1;
    i_ctrl.hold(2);
    check_pins();
    for (int c = 2; c < 8; c++) rd_chk(c);
    // Random register traffic, pins follow each write
    for (int k = 0; k < 12; k++) begin
      lfsr = lfsr_next(lfsr);
      wr(2 + k % 6, lfsr[7:0]);
      check_pins();
    end
    for (int c = 2; c < 8; c++) rd_chk(c);
    // Level registers track pins and level A ignores a write; sources hold 4 us
    wr(4, 8'hff); wr(5, 8'hff); wr(6, 8'h00); wr(7, 8'h00);
    lfsr = lfsr_next(lfsr);
    odExt = lfsr[7:0];
    ppExt = lfsr[15:8];
    i_ctrl.hold(`IOX_TIV_CYC);
    wr(0, ~odExt);
    rm[0] = odExt;
    rm[1] = ppExt;
    rd_chk(0);
    rd_chk(1);
    check("alert clear", {7'h0, changeAlertNOe}, 8'h00);
    // Change on bank A; reading bank B leaves it pending
    odExt[3] = ~odExt[3];
    rm[0] = odExt;
    wait_alert(1'b1);
    rd_chk(1);
    check("alert kept", {7'h0, alertPin}, 8'h00);
    // Bus clear as soon as the address acknowledge starts aborts the write
    fork
      i_ctrl.write_reg(me, 8'h04, 8'h00, ok);
      begin
        for (int n = 0; n < 400 && sdaOe !== 1'b1; n++) i_ctrl.hold(1);
        busClearN = 1'b0;
        i_ctrl.hold(2);
        check("sda release", {7'h0, sdaOe}, 8'h00);
        i_ctrl.hold(10);
        busClearN = 1'b1;
      end
    join
    check("aborted ack", {7'h0, ok}, 8'h00);
    check("alert after clear", {7'h0, changeAlertNOe}, 8'h01);
    i_ctrl.hold(20);
    rd_chk(4);
    rd_chk(0);
    check("alert dropped", {7'h0, changeAlertNOe}, 8'h00);
    // Masked bank B change raises nothing
    wr(7, 8'hff);
    ppExt = ~ppExt;
    i_ctrl.hold(`IOX_TIV_CYC);
    check("masked", {7'h0, changeAlertNOe}, 8'h00);
    // Foreign target addresses are not acknowledged
    for (int a = 0; a < 4; a++) begin
      if (a != 2) begin
        i_ctrl.write_reg({`IOX_ADDR_UPPER, a[1:0]}, 8'h04, 8'h5a, ok);
        check("foreign ack", {7'h0, ok}, 8'h00);
      end
    end
    rd_chk(4);
    // Clock spikes ignored; slow controller reads back
    i_ctrl.spike = 1'b1;
    wr(5, 8'h3c);
    i_ctrl.spike = 1'b0;
    i_ctrl.halfCyc = 20;
    rd_chk(5);
    i_ctrl.halfCyc = 8;
    check_pins();
    // Second power-up with swapped straps: new defaults and new address
    rst_n = 1'b0; addrSelectHi = 1'b0; addrSelectLo = 1'b1;
    repeat (12) @(posedge core_clk);
    #1 rst_n = 1'b1;
    me = {`IOX_ADDR_UPPER, 1'b0, 1'b1};
    rm = '{0, 0, 'h0f, 'h0f, 0, 0, 0, 0};
    i_ctrl.hold(2);
    check_pins();
    rd_chk(3);
    rd_chk(2);
    wrap_up();
  end
endmodule : test_i2c_sixteen_bit_io_expander
`default_nettype wire
